// ### hdl/tpgil_pkg.sv
// constants for the three-phase gate input logic
package tpgil_pkg;

    // input synchroniser
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT = 15;
    localparam int PIN_EN1 = 0;
    localparam int PIN_EN2 = 1;
    localparam int PIN_HI_N = 2;
    localparam int PIN_LO = 5;
    localparam int PIN_SRC = 8;
    localparam int PIN_OC = 11;
    localparam int PIN_CS_N = 12;
    localparam int PIN_SCLK = 13;
    localparam int PIN_SI = 14;
    // idle levels: chip select, serial clock, high-side controls high
    localparam logic [PIN_COUNT-1:0] PIN_RST = 15'h301C;

    // serial frame layout
    localparam int FRAME_BITS = 8;
    localparam int BIT_CNT_W = 4;
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 5;
    localparam int DATA_W = 5;
    localparam logic [2:0] OP_STATUS = 3'h0;
    localparam logic [2:0] OP_CLEAR = 3'h2;
    localparam logic [2:0] OP_DEADTIME = 3'h4;
    localparam logic [2:0] OP_UNLOCK = 3'h5;
    localparam logic [2:0] OP_SIMUL = 3'h6;
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 5'h15;

    // status byte shifted out on each frame
    localparam int ST_OC = 7;
    localparam int ST_OVERLAP = 6;
    localparam int ST_FRAME = 5;
    localparam int ST_SIMUL = 4;
    localparam int ST_UNLOCK = 3;

    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SCLK_TYP_KHZ = 3000;
    localparam int DT_STEP_NS = 100;
    localparam int DT_STEP_CYC =
        (DT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DT_CNT_W = 10;
    localparam logic [DATA_W-1:0] DT_CODE_RST = 5'h04;

    // serial port sequencer
    typedef enum logic [1:0] {
        TPGIL_SP_IDLE = 2'b00,
        TPGIL_SP_SHIFT = 2'b01,
        TPGIL_SP_EXEC = 2'b10
    } tpgil_sp_state_e;

endpackage

// ### hdl/tpgil_phase.sv
// one phase: enable gating, deadtime and overlap guard
module tpgil_phase #(
    parameter int DT_CNT_W = tpgil_pkg::DT_CNT_W
) (
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic dev_reset_n_i,
    // control
    input wire logic enable_i,
    input wire logic high_req_i,
    input wire logic low_req_i,
    input wire logic allow_simul_i,
    input wire logic [DT_CNT_W-1:0] dt_cycles_i,
    // gate drives and fault event
    output logic high_gate_o,
    output logic low_gate_o,
    output logic overlap_o
);

    logic [DT_CNT_W-1:0] dt_cnt;
    logic [DT_CNT_W-1:0] next_dt_cnt;
    logic next_high;
    logic next_low;

    wire want_high = enable_i & high_req_i;
    wire want_low = enable_i & low_req_i;
    wire clash = want_high & want_low & ~allow_simul_i;
    wire dt_done = (dt_cnt == '0);
    // complementary side must be off and deadtime spent, unless simultaneous drive is allowed
    wire high_ok = allow_simul_i | (~low_gate_o & dt_done);
    wire low_ok = allow_simul_i | (~high_gate_o & dt_done);
    wire turn_off = (high_gate_o & ~next_high) | (low_gate_o & ~next_low);

    assign next_high = want_high & ~clash & high_ok;
    assign next_low = want_low & ~clash & low_ok;
    assign next_dt_cnt = turn_off ? dt_cycles_i :
                         (dt_done ? dt_cnt : dt_cnt - 1'b1);

    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            high_gate_o <= 1'b0;
            low_gate_o <= 1'b0;
            overlap_o <= 1'b0;
            dt_cnt <= '0;
        end else if (!nrst_i) begin
            high_gate_o <= 1'b0;
            low_gate_o <= 1'b0;
            overlap_o <= 1'b0;
            dt_cnt <= '0;
        end else begin
            high_gate_o <= next_high;
            low_gate_o <= next_low;
            overlap_o <= clash;
            dt_cnt <= next_dt_cnt;
        end
    end

endmodule // tpgil_phase

// ### hdl/tpgil_top.sv
// three-phase gate input logic: pins, serial setup port and phases
//
// Behaviour
// - any gate turns on only while both enable inputs are high
// - high-side gate is requested by its active-low control input
// - low-side gate is requested by its active-high control input
// - serial input sampled on serial clock falling edge, MSB first
// - serial output floats while chip select high, drives once it falls
// - chip select low frames one command; traffic outside is ignored
// - phase level output low while source below half battery, else high
// - overcurrent comparator result driven on its own output
// - device reset input acts asynchronously, without the clock
// - deadtime inserted between one side off and the other side on, unless simultaneous drive is permitted
// - both sides of a phase on only after guarded serial permission
module tpgil_top #(
    parameter logic [tpgil_pkg::DATA_W-1:0] DT_CODE_RST =
        tpgil_pkg::DT_CODE_RST
) (
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic dev_reset_n_i,
    // enables
    input wire logic drive_enable_first_i,
    input wire logic drive_enable_second_i,
    // phase controls
    input wire logic phase_a_high_ctrl_n_i,
    input wire logic phase_b_high_ctrl_n_i,
    input wire logic phase_c_high_ctrl_n_i,
    input wire logic phase_a_low_ctrl_i,
    input wire logic phase_b_low_ctrl_i,
    input wire logic phase_c_low_ctrl_i,
    // comparator levels
    input wire logic phase_a_high_source_i,
    input wire logic phase_b_high_source_i,
    input wire logic phase_c_high_source_i,
    input wire logic overcurrent_cmp_i,
    // serial setup port
    input wire logic chip_sel_n_i,
    input wire logic ser_clk_i,
    input wire logic ser_in_i,
    output logic ser_out_o,
    output logic ser_out_en_o,
    // gate drives
    output logic [2:0] high_gate_o,
    output logic [2:0] low_gate_o,
    // status
    output logic phase_a_level_out_o,
    output logic phase_b_level_out_o,
    output logic phase_c_level_out_o,
    output logic overcurrent_flag_out_o,
    output logic fault_irq_o
);

    localparam int NP = tpgil_pkg::PIN_COUNT;
    localparam int SS = tpgil_pkg::SYNC_STAGES;
    localparam int FB = tpgil_pkg::FRAME_BITS;
    localparam int BW = tpgil_pkg::BIT_CNT_W;
    localparam int DW = tpgil_pkg::DATA_W;
    localparam int CW = tpgil_pkg::DT_CNT_W;

    // ---------------- pin synchronisers ----------------
    logic [NP-1:0] pins;
    logic [NP-1:0] pin_f;
    logic [SS-1:0] sync_q [NP];

    assign pins = {ser_in_i, ser_clk_i, chip_sel_n_i, overcurrent_cmp_i,
                   phase_c_high_source_i, phase_b_high_source_i,
                   phase_a_high_source_i,
                   phase_c_low_ctrl_i, phase_b_low_ctrl_i,
                   phase_a_low_ctrl_i,
                   phase_c_high_ctrl_n_i, phase_b_high_ctrl_n_i,
                   phase_a_high_ctrl_n_i,
                   drive_enable_second_i, drive_enable_first_i};

    // level changes once the second and third stages agree
    for (genvar g = 0; g < NP; g++) begin : g_sync
        always_ff @(posedge sys_clk_i) begin
            if (!nrst_i) begin
                sync_q[g] <= {SS{tpgil_pkg::PIN_RST[g]}};
                pin_f[g] <= tpgil_pkg::PIN_RST[g];
            end else begin
                sync_q[g] <= {sync_q[g][SS-2:0], pins[g]};
                if (sync_q[g][1] == sync_q[g][2]) begin
                    pin_f[g] <= sync_q[g][2];
                end
            end
        end
    end

    wire drv_enable = pin_f[tpgil_pkg::PIN_EN1] &
                      pin_f[tpgil_pkg::PIN_EN2];
    wire [2:0] high_req = ~pin_f[tpgil_pkg::PIN_HI_N +: 3];
    wire [2:0] low_req = pin_f[tpgil_pkg::PIN_LO +: 3];
    wire [2:0] src_above = pin_f[tpgil_pkg::PIN_SRC +: 3];
    wire oc_level = pin_f[tpgil_pkg::PIN_OC];
    wire cs_n = pin_f[tpgil_pkg::PIN_CS_N];
    wire sclk = pin_f[tpgil_pkg::PIN_SCLK];
    wire si = pin_f[tpgil_pkg::PIN_SI];

    // ---------------- serial clock edges ----------------
    logic sclk_prev;
    logic cs_prev;
    wire sclk_fall = sclk_prev & ~sclk;
    wire sclk_rise = ~sclk_prev & sclk;
    wire cs_fall = cs_prev & ~cs_n;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sclk_prev <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk;
            cs_prev <= cs_n;
        end
    end

    // ---------------- configuration and fault state ----------------
    tpgil_pkg::tpgil_sp_state_e sp_state;
    tpgil_pkg::tpgil_sp_state_e next_sp_state;
    logic [FB-1:0] shift_in;
    logic [FB-1:0] shift_out;
    logic [BW-1:0] bit_cnt;
    logic [DW-1:0] dt_code;
    logic allow_simul;
    logic unlocked;
    logic fault_oc;
    logic fault_overlap;
    logic fault_frame;
    logic [2:0] overlap_ev;

    wire [2:0] opcode = shift_in[tpgil_pkg::OP_MSB:tpgil_pkg::OP_LSB];
    wire [DW-1:0] op_data = shift_in[DW-1:0];
    wire frame_ok = (bit_cnt == BW'(FB));
    wire exec = (sp_state == tpgil_pkg::TPGIL_SP_EXEC);
    wire exec_ok = exec & frame_ok;
    wire do_clear = exec_ok & (opcode == tpgil_pkg::OP_CLEAR);
    wire do_dt = exec_ok & (opcode == tpgil_pkg::OP_DEADTIME);
    wire do_unlock = exec_ok & (opcode == tpgil_pkg::OP_UNLOCK) &
                     (op_data == tpgil_pkg::UNLOCK_KEY);
    // permission change only in the frame right after the key
    wire do_simul = exec_ok & (opcode == tpgil_pkg::OP_SIMUL) &
                    unlocked;
    wire [CW-1:0] dt_cycles =
        CW'(32'(dt_code) * tpgil_pkg::DT_STEP_CYC);

    wire [FB-1:0] status_byte = {fault_oc, fault_overlap, fault_frame,
                                 allow_simul, unlocked, 3'h0};

    // sticky faults: a new event wins over a clear in the same cycle
    wire next_fault_oc = oc_level | (fault_oc & ~do_clear);
    wire next_fault_overlap = (|overlap_ev) |
                              (fault_overlap & ~do_clear);
    wire next_fault_frame = (exec & ~frame_ok) |
                            (fault_frame & ~do_clear);

    // ---------------- serial sequencer ----------------
    always_comb begin
        next_sp_state = sp_state;
        case (sp_state)
            tpgil_pkg::TPGIL_SP_IDLE: begin
                if (cs_fall) begin
                    next_sp_state = tpgil_pkg::TPGIL_SP_SHIFT;
                end
            end
            tpgil_pkg::TPGIL_SP_SHIFT: begin
                if (cs_n) begin
                    next_sp_state = tpgil_pkg::TPGIL_SP_EXEC;
                end
            end
            tpgil_pkg::TPGIL_SP_EXEC: begin
                next_sp_state = tpgil_pkg::TPGIL_SP_IDLE;
            end
            default: begin
                next_sp_state = tpgil_pkg::TPGIL_SP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            sp_state <= tpgil_pkg::TPGIL_SP_IDLE;
        end else if (!nrst_i) begin
            sp_state <= tpgil_pkg::TPGIL_SP_IDLE;
        end else begin
            sp_state <= next_sp_state;
        end
    end

    // input shift: falling edge, MSB first, counted up to saturation
    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            shift_in <= '0;
            bit_cnt <= '0;
        end else if (!nrst_i) begin
            shift_in <= '0;
            bit_cnt <= '0;
        end else if (cs_fall) begin
            bit_cnt <= '0;
        end else if (sp_state == tpgil_pkg::TPGIL_SP_SHIFT && sclk_fall
                     && !cs_n) begin
            shift_in <= {shift_in[FB-2:0], si};
            if (bit_cnt != '1) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // output shift: status loaded at frame start, advanced on rise
    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            shift_out <= '0;
            ser_out_o <= 1'b0;
            ser_out_en_o <= 1'b0;
        end else if (!nrst_i) begin
            shift_out <= '0;
            ser_out_o <= 1'b0;
            ser_out_en_o <= 1'b0;
        end else begin
            ser_out_en_o <= ~cs_n;
            if (cs_fall) begin
                shift_out <= status_byte;
                ser_out_o <= status_byte[FB-1];
            end else if (sp_state == tpgil_pkg::TPGIL_SP_SHIFT &&
                         sclk_rise && !cs_n) begin
                shift_out <= {shift_out[FB-2:0], 1'b0};
                ser_out_o <= shift_out[FB-2];
            end
        end
    end

    // setup registers written by completed frames
    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            dt_code <= DT_CODE_RST;
            allow_simul <= 1'b0;
            unlocked <= 1'b0;
        end else if (!nrst_i) begin
            dt_code <= DT_CODE_RST;
            allow_simul <= 1'b0;
            unlocked <= 1'b0;
        end else if (exec) begin
            unlocked <= do_unlock;
            if (do_dt) begin
                dt_code <= op_data;
            end
            if (do_simul) begin
                allow_simul <= op_data[0];
            end
        end
    end

    // faults, interrupt and comparator outputs
    always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
        if (!dev_reset_n_i) begin
            fault_oc <= 1'b0;
            fault_overlap <= 1'b0;
            fault_frame <= 1'b0;
            fault_irq_o <= 1'b0;
            phase_a_level_out_o <= 1'b0;
            phase_b_level_out_o <= 1'b0;
            phase_c_level_out_o <= 1'b0;
            overcurrent_flag_out_o <= 1'b0;
        end else if (!nrst_i) begin
            fault_oc <= 1'b0;
            fault_overlap <= 1'b0;
            fault_frame <= 1'b0;
            fault_irq_o <= 1'b0;
            phase_a_level_out_o <= 1'b0;
            phase_b_level_out_o <= 1'b0;
            phase_c_level_out_o <= 1'b0;
            overcurrent_flag_out_o <= 1'b0;
        end else begin
            fault_oc <= next_fault_oc;
            fault_overlap <= next_fault_overlap;
            fault_frame <= next_fault_frame;
            fault_irq_o <= next_fault_oc | next_fault_overlap |
                           next_fault_frame;
            phase_a_level_out_o <= src_above[0];
            phase_b_level_out_o <= src_above[1];
            phase_c_level_out_o <= src_above[2];
            overcurrent_flag_out_o <= oc_level;
        end
    end

    // ---------------- phases ----------------
    for (genvar p = 0; p < 3; p++) begin : g_phase
        tpgil_phase #(
            .DT_CNT_W(CW)
        ) u_phase (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .dev_reset_n_i(dev_reset_n_i),
            .enable_i(drv_enable),
            .high_req_i(high_req[p]),
            .low_req_i(low_req[p]),
            .allow_simul_i(allow_simul),
            .dt_cycles_i(dt_cycles),
            .high_gate_o(high_gate_o[p]),
            .low_gate_o(low_gate_o[p]),
            .overlap_o(overlap_ev[p])
        );
    end

endmodule // tpgil_top

// ### sim/tpgil_top_props.sv
// port assertions for the three-phase gate input logic
module tpgil_top_props (
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic dev_reset_n_i,
    // pin inputs
    input wire logic drive_enable_first_i,
    input wire logic drive_enable_second_i,
    input wire logic phase_a_high_ctrl_n_i,
    input wire logic phase_b_high_ctrl_n_i,
    input wire logic phase_c_high_ctrl_n_i,
    input wire logic phase_a_low_ctrl_i,
    input wire logic phase_b_low_ctrl_i,
    input wire logic phase_c_low_ctrl_i,
    input wire logic phase_a_high_source_i,
    input wire logic phase_b_high_source_i,
    input wire logic phase_c_high_source_i,
    input wire logic overcurrent_cmp_i,
    input wire logic chip_sel_n_i,
    // outputs
    input wire logic ser_out_en_o,
    input wire logic [2:0] high_gate_o,
    input wire logic [2:0] low_gate_o,
    input wire logic phase_a_level_out_o,
    input wire logic phase_b_level_out_o,
    input wire logic phase_c_level_out_o,
    input wire logic overcurrent_flag_out_o,
    input wire logic fault_irq_o
);
    wire logic [2:0] hreq = ~{phase_c_high_ctrl_n_i, phase_b_high_ctrl_n_i,
        phase_a_high_ctrl_n_i};
    wire logic [2:0] lreq = {phase_c_low_ctrl_i, phase_b_low_ctrl_i,
        phase_a_low_ctrl_i};
    wire logic [2:0] src = {phase_c_high_source_i, phase_b_high_source_i,
        phase_a_high_source_i};
    wire logic [2:0] lvl = {phase_c_level_out_o, phase_b_level_out_o,
        phase_a_level_out_o};
    wire logic en = drive_enable_first_i & drive_enable_second_i;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i || !dev_reset_n_i);

    property p_enable_off;
        !en [*8] |-> high_gate_o == 3'h0 && low_gate_o == 3'h0;
    endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("gate on while drive disabled");
    // pin to gate latency spans four to seven samples
    property p_high_req;
        (high_gate_o & ~($past(hreq, 4) | $past(hreq, 5) | $past(hreq, 6)
            | $past(hreq, 7))) == 3'h0;
    endproperty
    a_high_req: assert property (p_high_req)
        else $error("high gate on without request");
    property p_low_req;
        (low_gate_o & ~($past(lreq, 4) | $past(lreq, 5) | $past(lreq, 6)
            | $past(lreq, 7))) == 3'h0;
    endproperty
    a_low_req: assert property (p_low_req)
        else $error("low gate on without request");
    property p_sout_float;
        chip_sel_n_i [*8] ##1 chip_sel_n_i [*4] |-> !ser_out_en_o;
    endproperty
    a_sout_float: assert property (p_sout_float)
        else $error("serial out driven while deselected");
    property p_sout_start;
        $rose(ser_out_en_o) |-> !chip_sel_n_i && !$past(chip_sel_n_i, 3);
    endproperty
    a_sout_start: assert property (p_sout_start)
        else $error("serial out driven before select");
    property p_level;
        ($stable(src) && dev_reset_n_i) [*8] |-> lvl == src;
    endproperty
    a_level: assert property (p_level)
        else $error("phase level output wrong");
    property p_ocflag;
        $stable(overcurrent_cmp_i) [*8] |->
            overcurrent_flag_out_o == overcurrent_cmp_i;
    endproperty
    a_ocflag: assert property (p_ocflag)
        else $error("overcurrent output wrong");
    property p_devrst;
        disable iff (!nrst_i)
        !dev_reset_n_i |->
            {high_gate_o, low_gate_o, fault_irq_o, ser_out_en_o} == 8'h00;
    endproperty
    a_devrst: assert property (p_devrst)
        else $error("outputs not cleared by device reset");
    property p_deadtime;
        (high_gate_o & $past(low_gate_o) & ~low_gate_o) == 3'h0
            && (low_gate_o & $past(high_gate_o) & ~high_gate_o) == 3'h0;
    endproperty
    a_deadtime: assert property (p_deadtime)
        else $error("gate swap without dead time");
    property p_irq;
        overcurrent_cmp_i [*8] |-> fault_irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("no interrupt on overcurrent");
endmodule // tpgil_top_props

bind tpgil_top tpgil_top_props u_props (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .dev_reset_n_i(dev_reset_n_i),
    .drive_enable_first_i(drive_enable_first_i),
    .drive_enable_second_i(drive_enable_second_i),
    .phase_a_high_ctrl_n_i(phase_a_high_ctrl_n_i),
    .phase_b_high_ctrl_n_i(phase_b_high_ctrl_n_i),
    .phase_c_high_ctrl_n_i(phase_c_high_ctrl_n_i),
    .phase_a_low_ctrl_i(phase_a_low_ctrl_i),
    .phase_b_low_ctrl_i(phase_b_low_ctrl_i),
    .phase_c_low_ctrl_i(phase_c_low_ctrl_i),
    .phase_a_high_source_i(phase_a_high_source_i),
    .phase_b_high_source_i(phase_b_high_source_i),
    .phase_c_high_source_i(phase_c_high_source_i),
    .overcurrent_cmp_i(overcurrent_cmp_i), .chip_sel_n_i(chip_sel_n_i),
    .ser_out_en_o(ser_out_en_o), .high_gate_o(high_gate_o),
    .low_gate_o(low_gate_o), .phase_a_level_out_o(phase_a_level_out_o),
    .phase_b_level_out_o(phase_b_level_out_o),
    .phase_c_level_out_o(phase_c_level_out_o),
    .overcurrent_flag_out_o(overcurrent_flag_out_o),
    .fault_irq_o(fault_irq_o)
);

// ### sim/tpgil_mcu.sv
// controller model driving the serial setup port
module tpgil_mcu (
    // serial port
    output logic chip_sel_n_o,
    output logic ser_clk_o,
    output logic ser_in_o,
    input wire logic ser_out_i,
    input wire logic ser_out_en_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;

    // clock idles high, still between frames
    initial begin
        chip_sel_n_o = 1'b1;
        ser_clk_o = 1'b1;
        ser_in_o = 1'b0;
    end

    task automatic frame(input logic [7:0] cmd, input int nbits,
            output logic [7:0] st);
        int i;
        st = 8'h00;
        chip_sel_n_o = 1'b0;
        #(4 * HALF);
        for (i = 0; i < nbits; i++) begin
            ser_in_o = cmd[7 - i % 8];
            #HALF ser_clk_o = 1'b0;
            st = {st[6:0], ser_out_en_i ? ser_out_i : 1'bx};
            #HALF ser_clk_o = 1'b1;
        end
        #HALF chip_sel_n_o = 1'b1;
        // data line no longer holds its last bit
        ser_in_o = ~ser_in_o;
        #(4 * HALF);
    endtask
endmodule // tpgil_mcu

// ### sim/tpgil_top_test.sv
// self-checking bench for the three-phase gate input logic
module tpgil_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 30000;
    logic clk, nrst, drst, en1, en2, oc, so, so_en, irq, oc_flag;
    logic cs_n, sclk, si;
    logic [2:0] hi_n, lo, src, hg, lg, lvl;
    logic [7:0] st;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire logic [5:0] gates = {lg, hg};

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    tpgil_top dut (
        .sys_clk_i(clk), .nrst_i(nrst), .dev_reset_n_i(drst),
        .drive_enable_first_i(en1), .drive_enable_second_i(en2),
        .phase_a_high_ctrl_n_i(hi_n[0]), .phase_b_high_ctrl_n_i(hi_n[1]),
        .phase_c_high_ctrl_n_i(hi_n[2]), .phase_a_low_ctrl_i(lo[0]),
        .phase_b_low_ctrl_i(lo[1]), .phase_c_low_ctrl_i(lo[2]),
        .phase_a_high_source_i(src[0]), .phase_b_high_source_i(src[1]),
        .phase_c_high_source_i(src[2]), .overcurrent_cmp_i(oc),
        .chip_sel_n_i(cs_n), .ser_clk_i(sclk), .ser_in_i(si),
        .ser_out_o(so), .ser_out_en_o(so_en), .high_gate_o(hg),
        .low_gate_o(lg), .phase_a_level_out_o(lvl[0]),
        .phase_b_level_out_o(lvl[1]), .phase_c_level_out_o(lvl[2]),
        .overcurrent_flag_out_o(oc_flag), .fault_irq_o(irq)
    );
    tpgil_mcu mcu (
        .chip_sel_n_o(cs_n), .ser_clk_o(sclk), .ser_in_o(si),
        .ser_out_i(so), .ser_out_en_i(so_en)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string msg);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
                got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            summarize();
        end
    end

    task automatic send(input logic [2:0] op, input logic [4:0] data,
            input int nbits);
        mcu.frame({op, data}, nbits, st);
        @(negedge clk);
    endtask

    // counts falling edges until gate bit b reaches v
    task automatic wait_gate(input int b, input logic v, output int n);
        n = 0;
        while (gates[b] !== v && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (n == 600)
            chk(16'h1, 16'h0, "gate wait");
    endtask

    task automatic t_idle();
        chk({15'h0, so_en}, 16'h0, "idle enable");
        send(tpgil_pkg::OP_STATUS, 5'h00, 8);
        chk({8'h0, st}, 16'h0, "reset status");
    endtask

    task automatic t_deadtime();
        logic [4:0] code [3] = '{tpgil_pkg::DT_CODE_RST, 5'h00, 5'h1F};
        int n;
        for (int ph = 0; ph < 3; ph++) begin
            if (ph > 0)
                send(tpgil_pkg::OP_DEADTIME, code[ph], 8);
            hi_n[ph] = 1'b0;
            wait_gate(ph, 1'b1, n);
            chk({13'h0, hg}, 16'(1 << ph), "high on");
            hi_n[ph] = 1'b1;
            lo[ph] = 1'b1;
            wait_gate(ph, 1'b0, n);
            wait_gate(ph + 3, 1'b1, n);
            chk(16'(n), 16'(code[ph] * tpgil_pkg::DT_STEP_CYC + 1),
                "dead time");
            chk({13'h0, lg}, 16'(1 << ph), "low on");
            lo[ph] = 1'b0;
            wait_gate(ph + 3, 1'b0, n);
        end
    endtask

    task automatic t_enable();
        int n;
        hi_n[0] = 1'b0;
        wait_gate(0, 1'b1, n);
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                en1 = 1'b0;
            else
                en2 = 1'b0;
            wait_gate(0, 1'b0, n);
            chk(16'(n < 8), 16'h1, "disable");
            en1 = 1'b1;
            en2 = 1'b1;
            wait_gate(0, 1'b1, n);
        end
        hi_n[0] = 1'b1;
        wait_gate(0, 1'b0, n);
    endtask

    task automatic t_levels();
        for (int k = 0; k < 4; k++) begin
            src = 3'(k * 3);
            oc = k[0];
            repeat (8) @(negedge clk);
            chk({12'h0, oc_flag, lvl}, {12'h0, oc, src}, "levels");
        end
        oc = 1'b0;
        chk({15'h0, irq}, 16'h1, "overcurrent irq");
        send(tpgil_pkg::OP_STATUS, 5'h00, 8);
        chk({8'h0, st}, 16'h0080, "overcurrent status");
        send(tpgil_pkg::OP_CLEAR, 5'h00, 8);
        chk({15'h0, irq}, 16'h0, "cleared");
    endtask

    task automatic t_frame();
        for (int k = 7; k < 10; k += 2) begin
            send(tpgil_pkg::OP_DEADTIME, 5'h00, k);
            chk({15'h0, irq}, 16'h1, "frame irq");
            send(tpgil_pkg::OP_STATUS, 5'h00, 8);
            chk({8'h0, st}, 16'h0020, "frame status");
            send(tpgil_pkg::OP_CLEAR, 5'h00, 8);
        end
    endtask

    task automatic t_devrst();
        int n;
        lo[1] = 1'b1;
        wait_gate(4, 1'b1, n);
        drst = 1'b0;
        #1;
        chk({10'h0, hg, lg}, 16'h0, "async clear");
        @(negedge clk);
        drst = 1'b1;
        wait_gate(4, 1'b1, n);
        lo[1] = 1'b0;
        wait_gate(4, 1'b0, n);
    endtask

    task automatic t_overlap();
        int n;
        send(tpgil_pkg::OP_SIMUL, 5'h01, 8);
        hi_n[1] = 1'b0;
        lo[1] = 1'b1;
        repeat (10) @(negedge clk);
        chk({10'h0, hg, lg}, 16'h0, "overlap blocked");
        chk({15'h0, irq}, 16'h1, "overlap irq");
        send(tpgil_pkg::OP_STATUS, 5'h00, 8);
        chk({8'h0, st}, 16'h0040, "overlap status");
        hi_n[1] = 1'b1;
        lo[1] = 1'b0;
        send(tpgil_pkg::OP_CLEAR, 5'h00, 8);
        send(tpgil_pkg::OP_UNLOCK, tpgil_pkg::UNLOCK_KEY, 8);
        send(tpgil_pkg::OP_SIMUL, 5'h01, 8);
        send(tpgil_pkg::OP_STATUS, 5'h00, 8);
        chk({8'h0, st & 8'hF0}, 16'h0010, "permission");
        hi_n[1] = 1'b0;
        lo[1] = 1'b1;
        wait_gate(4, 1'b1, n);
        repeat (2) @(negedge clk);
        chk({10'h0, hg, lg}, 16'h0012, "both on");
        hi_n[1] = 1'b1;
        lo[1] = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    initial begin
        nrst = 1'b0;
        drst = 1'b1;
        en1 = 1'b1;
        en2 = 1'b1;
        hi_n = 3'h7;
        lo = 3'h0;
        src = 3'h0;
        oc = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        t_idle();
        t_deadtime();
        t_enable();
        t_levels();
        t_frame();
        t_devrst();
        t_overlap();
        summarize();
    end
endmodule // tpgil_top_test
